// file: src/standby_pkg.sv
package standby_pkg;
	// wishbone register byte offsets
	localparam logic [3:0] ADDR_MODE = 4'h0;
	localparam logic [3:0] ADDR_CTRL = 4'h4;
	localparam logic [3:0] ADDR_CLKSEL = 4'h8;
	localparam logic [3:0] ADDR_STATUS = 4'hC;
	// power_save_mode_reg fields
	localparam int DEPTH_BIT = 0;
	// power_save_control_reg fields
	localparam int TRIGGER_BIT = 1;
	// clock-source select register fields
	localparam int SEL_TMR8_0 = 0;
	localparam int SEL_TMR8_1 = 1;
	localparam int SEL_WATCH_MAIN = 2;
	localparam int SEL_TIMER_H_CHANNEL1_SUB = 3;
	localparam int SEL_WDT2_SUB = 4;
	localparam int SEL_CSI0 = 5;
	localparam int SEL_CSI1 = 6;
	localparam int SEL_CSI2 = 7;
	localparam int SEL_UART0_EXT = 8;
	localparam int SEL_SUB_USED = 9;
	localparam int SEL_W = 10;
	localparam int CSI_N = 3;
	// gated clock enable vector positions
	localparam int G_CPU = 0;
	localparam int G_INTC = 1;
	localparam int G_TMR16 = 2;
	localparam int G_TMR8_0 = 3;
	localparam int G_TMR8_1 = 4;
	localparam int G_TMH0 = 5;
	localparam int G_TIMER_H_CHANNEL1 = 6;
	localparam int G_WATCH = 7;
	localparam int G_WDT1 = 8;
	localparam int G_WDT2 = 9;
	localparam int G_CSI0 = 10;
	localparam int G_CSIA = 13;
	localparam int G_I2C = 14;
	localparam int G_UART0 = 15;
	localparam int G_UART12 = 16;
	localparam int G_ADC = 17;
	localparam int G_DAC = 18;
	localparam int G_RTO = 19;
	localparam int G_KEY = 20;
	localparam int G_W = 21;
	localparam int EXT_INT_N = 7;
	localparam int PRIO_W = 3;
	// oscillation stabilization wait in ns and cycles at 40 MHz
	localparam int CLK_NS = 25;
	localparam int OSC_STAB_NS = 50000;
	localparam int OSC_STAB_CYC = OSC_STAB_NS / CLK_NS;
	localparam logic [15:0] OSC_CNT_ONE = 16'h0001;
	typedef enum logic [2:0] {
		ST_NORMAL = 3'b000,
		ST_LIGHT = 3'b001,
		ST_DEEP = 3'b010,
		ST_STAB = 3'b011,
		ST_RESUME = 3'b100
	} standby_state_t;
	typedef enum logic [1:0] {
		WAKE_NEXT = 2'b00,
		WAKE_BRANCH = 2'b01,
		WAKE_PEND = 2'b10
	} wake_action_t;
endpackage

// file: src/wake_arbiter.sv
`timescale 1ns/10ps
module wake_arbiter (
	input wire logic nmi,
	input wire logic [standby_pkg::EXT_INT_N-1:0] ext_int,
	input wire logic [standby_pkg::EXT_INT_N-1:0] ext_int_mask,
	input wire logic periph_int,
	input wire logic [standby_pkg::PRIO_W-1:0] periph_prio,
	input wire logic in_service,
	input wire logic [standby_pkg::PRIO_W-1:0] service_prio,
	input wire logic interrupts_enabled_state,
	output logic wake,
	output logic wake_nmi,
	output standby_pkg::wake_action_t action
);
	// lower prio value = higher priority; ext pins share the peripheral prio level
	logic maskable;
	logic higher;
	assign maskable = (|(ext_int & ~ext_int_mask)) | periph_int;
	assign wake = nmi | maskable;
	assign wake_nmi = nmi;
	assign higher = !in_service || (periph_prio < service_prio);
	always_comb begin
		if (nmi) begin
			action = standby_pkg::WAKE_BRANCH;
		end else if (maskable && in_service && !higher) begin
			action = standby_pkg::WAKE_PEND;
		end else if (maskable && interrupts_enabled_state) begin
			action = standby_pkg::WAKE_BRANCH;
		end else begin
			action = standby_pkg::WAKE_NEXT;
		end
	end
endmodule

// file: src/standby_mode_controller.sv
`timescale 1ns/10ps
module standby_mode_controller (
	input wire logic mclk,
	input wire logic reset,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic nmi,
	input wire logic [standby_pkg::EXT_INT_N-1:0] ext_int,
	input wire logic [standby_pkg::EXT_INT_N-1:0] ext_int_mask,
	input wire logic periph_int,
	input wire logic [standby_pkg::PRIO_W-1:0] periph_prio,
	input wire logic in_service,
	input wire logic [standby_pkg::PRIO_W-1:0] service_prio,
	input wire logic interrupts_enabled_state,
	output logic [standby_pkg::G_W-1:0] clk_en,
	output logic main_osc_en,
	output logic sub_osc_en,
	output logic port_hold,
	output logic ram_retain,
	output logic cpu_halt,
	output logic wake_pulse,
	output logic wake_ack,
	output logic wake_pending,
	output logic wake_branch
);
	standby_pkg::standby_state_t state_reg;
	standby_pkg::standby_state_t state_next;
	logic depth_reg;
	logic [standby_pkg::SEL_W-1:0] sel_reg;
	logic [15:0] stab_cnt_reg;
	logic trigger_wr;
	logic wb_hit;
	logic wake;
	logic wake_nmi;
	standby_pkg::wake_action_t action;
	logic [standby_pkg::G_W-1:0] light_en;
	logic [standby_pkg::G_W-1:0] deep_en;
	logic [31:0] rd_data;
	logic sub_used;
	localparam logic [15:0] OSC_CNT_ONE_L = standby_pkg::OSC_CNT_ONE;
	localparam logic [15:0] OSC_CNT_LOAD = 16'(standby_pkg::OSC_STAB_CYC);

	function automatic logic lane0(input logic [3:0] sel, input logic we, input logic hit);
		lane0 = hit && we && sel[0];
	endfunction

	function automatic logic lane1(input logic [3:0] sel, input logic we, input logic hit);
		lane1 = hit && we && sel[1];
	endfunction

	assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign sub_used = sel_reg[standby_pkg::SEL_SUB_USED];

	// single-cycle ack one edge after the request is seen
	always_ff @(posedge mclk) begin
		if (reset) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= wb_hit;
		end
	end

	always_comb begin
		rd_data = 32'h0000_0000;
		case (wb_adr_i)
			standby_pkg::ADDR_MODE: rd_data[standby_pkg::DEPTH_BIT] = depth_reg;
			standby_pkg::ADDR_CTRL: rd_data = 32'h0000_0000;
			standby_pkg::ADDR_CLKSEL: rd_data[standby_pkg::SEL_W-1:0] = sel_reg;
			standby_pkg::ADDR_STATUS: rd_data[2:0] = state_reg;
			default: rd_data = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (wb_hit && !wb_we_i) begin
			wb_dat_o <= rd_data;
		end
	end

	// power_save_mode_reg
	always_ff @(posedge mclk) begin
		if (reset) begin
			depth_reg <= 1'b0;
		end else if (lane0(wb_sel_i, wb_we_i, wb_hit) && wb_adr_i == standby_pkg::ADDR_MODE) begin
			depth_reg <= wb_dat_i[standby_pkg::DEPTH_BIT];
		end
	end

	// clock source selection register
	always_ff @(posedge mclk) begin
		if (reset) begin
			sel_reg <= '0;
		end else if (wb_adr_i == standby_pkg::ADDR_CLKSEL) begin
			if (lane0(wb_sel_i, wb_we_i, wb_hit)) begin
				sel_reg[7:0] <= wb_dat_i[7:0];
			end
			if (lane1(wb_sel_i, wb_we_i, wb_hit)) begin
				sel_reg[standby_pkg::SEL_W-1:8] <= wb_dat_i[standby_pkg::SEL_W-1:8];
			end
		end
	end

	// power_save_control_reg: standby_trigger is write-only, self clearing
	assign trigger_wr = lane0(wb_sel_i, wb_we_i, wb_hit) && wb_adr_i == standby_pkg::ADDR_CTRL
		&& wb_dat_i[standby_pkg::TRIGGER_BIT];

	wake_arbiter u_wake (
		.nmi(nmi),
		.ext_int(ext_int),
		.ext_int_mask(ext_int_mask),
		.periph_int(periph_int),
		.periph_prio(periph_prio),
		.in_service(in_service),
		.service_prio(service_prio),
		.interrupts_enabled_state(interrupts_enabled_state),
		.wake(wake),
		.wake_nmi(wake_nmi),
		.action(action)
	);

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			standby_pkg::ST_NORMAL: begin
				if (trigger_wr && depth_reg) begin
					state_next = standby_pkg::ST_DEEP;
				end else if (trigger_wr) begin
					state_next = standby_pkg::ST_LIGHT;
				end
			end
			standby_pkg::ST_LIGHT: begin
				if (wake) begin
					state_next = standby_pkg::ST_RESUME;
				end
			end
			standby_pkg::ST_DEEP: begin
				if (wake) begin
					state_next = standby_pkg::ST_STAB;
				end
			end
			standby_pkg::ST_STAB: begin
				if (stab_cnt_reg == OSC_CNT_ONE_L) begin
					state_next = standby_pkg::ST_RESUME;
				end
			end
			standby_pkg::ST_RESUME: state_next = standby_pkg::ST_NORMAL;
			default: state_next = standby_pkg::ST_NORMAL;
		endcase
	end

	// reset pin returns everything through the normal reset path
	always_ff @(posedge mclk) begin
		if (reset) begin
			state_reg <= standby_pkg::ST_NORMAL;
		end else begin
			state_reg <= state_next;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			stab_cnt_reg <= 16'h0000;
		end else if (state_reg == standby_pkg::ST_DEEP && wake) begin
			stab_cnt_reg <= OSC_CNT_LOAD;
		end else if (state_reg == standby_pkg::ST_STAB && stab_cnt_reg != 16'h0000) begin
			stab_cnt_reg <= stab_cnt_reg - OSC_CNT_ONE_L;
		end
	end

	// wake outcome latched at the release, held until the next release or reset
	always_ff @(posedge mclk) begin
		if (reset) begin
			wake_ack <= 1'b0;
			wake_pending <= 1'b0;
			wake_branch <= 1'b0;
		end else if ((state_reg == standby_pkg::ST_LIGHT || state_reg == standby_pkg::ST_DEEP) && wake) begin
			wake_ack <= action != standby_pkg::WAKE_PEND;
			wake_pending <= action == standby_pkg::WAKE_PEND;
			wake_branch <= action == standby_pkg::WAKE_BRANCH || wake_nmi;
		end
	end

	assign wake_pulse = state_reg == standby_pkg::ST_RESUME;

	// light standby: oscillator runs, external and subclock users, the watch timer on main clock and the key interrupt keep a clock
	always_comb begin
		light_en = '0;
		light_en[standby_pkg::G_TMR8_0] = sel_reg[standby_pkg::SEL_TMR8_0];
		light_en[standby_pkg::G_TMR8_1] = sel_reg[standby_pkg::SEL_TMR8_1];
		light_en[standby_pkg::G_WATCH] = sub_used || sel_reg[standby_pkg::SEL_WATCH_MAIN];
		light_en[standby_pkg::G_TIMER_H_CHANNEL1] = sub_used && sel_reg[standby_pkg::SEL_TIMER_H_CHANNEL1_SUB];
		light_en[standby_pkg::G_WDT2] = sub_used && sel_reg[standby_pkg::SEL_WDT2_SUB];
		light_en[standby_pkg::G_UART0] = sel_reg[standby_pkg::SEL_UART0_EXT];
		light_en[standby_pkg::G_KEY] = 1'b1;
	end

	// deep standby: only subclock or external clock users and the key interrupt survive
	always_comb begin
		deep_en = '0;
		deep_en[standby_pkg::G_TMR8_0] = sel_reg[standby_pkg::SEL_TMR8_0];
		deep_en[standby_pkg::G_TMR8_1] = sel_reg[standby_pkg::SEL_TMR8_1];
		deep_en[standby_pkg::G_WATCH] = sub_used;
		deep_en[standby_pkg::G_TIMER_H_CHANNEL1] = sub_used && sel_reg[standby_pkg::SEL_TIMER_H_CHANNEL1_SUB];
		deep_en[standby_pkg::G_WDT2] = sub_used && sel_reg[standby_pkg::SEL_WDT2_SUB];
		deep_en[standby_pkg::G_UART0] = sel_reg[standby_pkg::SEL_UART0_EXT];
		deep_en[standby_pkg::G_KEY] = 1'b1;
	end

	logic [standby_pkg::G_W-1:0] csi_bits;
	genvar gi;
	generate
		for (gi = 0; gi < standby_pkg::CSI_N; gi++) begin : g_csi
			assign csi_bits[standby_pkg::G_CSI0+gi] = sel_reg[standby_pkg::SEL_CSI0+gi];
		end
	endgenerate
	assign csi_bits[standby_pkg::G_CSI0-1:0] = '0;
	assign csi_bits[standby_pkg::G_W-1:standby_pkg::G_CSI0+standby_pkg::CSI_N] = '0;

	// registered clock enables and control levels
	always_ff @(posedge mclk) begin
		if (reset) begin
			clk_en <= '1;
		end else begin
			case (state_next)
				standby_pkg::ST_LIGHT: clk_en <= light_en | csi_bits;
				standby_pkg::ST_DEEP, standby_pkg::ST_STAB: clk_en <= deep_en | csi_bits;
				default: clk_en <= '1;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			main_osc_en <= 1'b1;
			sub_osc_en <= 1'b0;
			port_hold <= 1'b0;
			ram_retain <= 1'b0;
			cpu_halt <= 1'b0;
		end else begin
			main_osc_en <= !(state_next == standby_pkg::ST_DEEP);
			sub_osc_en <= sub_used;
			port_hold <= state_next != standby_pkg::ST_NORMAL && state_next != standby_pkg::ST_RESUME;
			ram_retain <= state_next != standby_pkg::ST_NORMAL && state_next != standby_pkg::ST_RESUME;
			cpu_halt <= state_next != standby_pkg::ST_NORMAL && state_next != standby_pkg::ST_RESUME;
		end
	end

	sequence s_deep_wake;
		state_reg == standby_pkg::ST_DEEP && wake;
	endsequence

	sequence s_stab_run;
		state_reg == standby_pkg::ST_STAB;
	endsequence

	AST_DEEP_ENTRY: assert property (@(posedge mclk) disable iff (reset)
		state_reg == standby_pkg::ST_NORMAL && trigger_wr && depth_reg |=> state_reg == standby_pkg::ST_DEEP)
		else $error("deep standby not entered");
	AST_LIGHT_ENTRY: assert property (@(posedge mclk) disable iff (reset)
		state_reg == standby_pkg::ST_NORMAL && trigger_wr && !depth_reg |=> state_reg == standby_pkg::ST_LIGHT)
		else $error("light standby not entered");
	AST_DEEP_OSC: assert property (@(posedge mclk) disable iff (reset)
		state_reg == standby_pkg::ST_DEEP |-> !main_osc_en && !clk_en[standby_pkg::G_CPU])
		else $error("oscillator or cpu clock on in deep standby");
	AST_DEEP_WAKE: assert property (@(posedge mclk) disable iff (reset)
		s_deep_wake |=> s_stab_run)
		else $error("deep wake did not start stabilization");
	AST_STAB_HOLD: assert property (@(posedge mclk) disable iff (reset)
		s_deep_wake |=> (s_stab_run [*8]))
		else $error("stabilization wait cut short");
	AST_LIGHT_FAST: assert property (@(posedge mclk) disable iff (reset)
		state_reg == standby_pkg::ST_LIGHT && wake |=> wake_pulse ##1 state_reg == standby_pkg::ST_NORMAL)
		else $error("light release not immediate");
	AST_LIGHT_OSC: assert property (@(posedge mclk) disable iff (reset)
		state_reg == standby_pkg::ST_LIGHT |-> main_osc_en && !clk_en[standby_pkg::G_CPU] && !clk_en[standby_pkg::G_ADC])
		else $error("light standby gating wrong");
	AST_PEND: assert property (@(posedge mclk) disable iff (reset)
		state_reg == standby_pkg::ST_LIGHT && wake && action == standby_pkg::WAKE_PEND |=> wake_pending && !wake_ack)
		else $error("lower priority request acknowledged");
	AST_HOLD: assert property (@(posedge mclk) disable iff (reset)
		state_reg == standby_pkg::ST_LIGHT |-> port_hold && ram_retain && cpu_halt)
		else $error("state not held in light standby");
	AST_STAB_LOAD: assert property (@(posedge mclk) disable iff (reset)
		s_deep_wake |=> stab_cnt_reg == OSC_CNT_LOAD)
		else $error("stabilization count not loaded");
	AST_STAB_WAIT: assert property (@(posedge mclk) disable iff (reset)
		state_reg == standby_pkg::ST_STAB && stab_cnt_reg != OSC_CNT_ONE_L
		|=> state_reg == standby_pkg::ST_STAB)
		else $error("stabilization left before count expired");
	AST_DEEP_STAY: assert property (@(posedge mclk) disable iff (reset)
		state_reg == standby_pkg::ST_DEEP && !wake |=> state_reg == standby_pkg::ST_DEEP)
		else $error("deep standby left without a wake source");
	AST_RESUME_NORMAL: assert property (@(posedge mclk) disable iff (reset)
		state_reg == standby_pkg::ST_RESUME
		|=> state_reg == standby_pkg::ST_NORMAL && main_osc_en && !cpu_halt)
		else $error("release did not return to normal operation");
	AST_NMI_ACK: assert property (@(posedge mclk) disable iff (reset)
		(state_reg == standby_pkg::ST_LIGHT || state_reg == standby_pkg::ST_DEEP) && wake_nmi
		|=> wake_ack && wake_branch)
		else $error("non-maskable wake not acknowledged");
	AST_DI_NEXT: assert property (@(posedge mclk) disable iff (reset)
		(state_reg == standby_pkg::ST_LIGHT || state_reg == standby_pkg::ST_DEEP) && wake && !wake_nmi
		&& !interrupts_enabled_state |=> !wake_branch)
		else $error("branch taken with interrupts disabled");
	AST_LIGHT_GATE: assert property (@(posedge mclk) disable iff (reset)
		state_reg == standby_pkg::ST_LIGHT |-> !clk_en[standby_pkg::G_INTC] && !clk_en[standby_pkg::G_TMR16]
		&& !clk_en[standby_pkg::G_CSIA] && !clk_en[standby_pkg::G_I2C] && !clk_en[standby_pkg::G_UART12])
		else $error("stopped unit still clocked in light standby");
	AST_DEEP_GATE: assert property (@(posedge mclk) disable iff (reset)
		state_reg == standby_pkg::ST_DEEP |-> !clk_en[standby_pkg::G_INTC] && !clk_en[standby_pkg::G_TMH0]
		&& !clk_en[standby_pkg::G_WDT1] && !clk_en[standby_pkg::G_ADC] && !clk_en[standby_pkg::G_DAC])
		else $error("stopped unit still clocked in deep standby");
	AST_RESET_NORMAL: assert property (@(posedge mclk)
		reset |=> state_reg == standby_pkg::ST_NORMAL && clk_en == '1 && main_osc_en && !cpu_halt)
		else $error("reset did not restore normal operation");
endmodule

// file: dv/irq_source_model.sv
`timescale 1ns/10ps
// raises one wake request on fire and holds it until the controller resumes
module irq_source_model (
	input wire logic mclk,
	input wire logic reset,
	input wire logic fire,
	input wire logic [1:0] src,
	input wire logic [2:0] prio,
	input wire logic wake_pulse,
	output logic nmi,
	output logic [standby_pkg::EXT_INT_N-1:0] ext_int,
	output logic periph_int,
	output logic [standby_pkg::PRIO_W-1:0] periph_prio
);
	always @(posedge mclk) begin
		if (reset || wake_pulse) begin
			nmi <= 1'h0;
			ext_int <= 7'h00;
			periph_int <= 1'h0;
			periph_prio <= 3'h7;
		end else if (fire) begin
			nmi <= (src == 2'h0);
			ext_int <= (src == 2'h1) ? (7'h01 << prio) : 7'h00;
			periph_int <= (src == 2'h2);
			periph_prio <= prio;
		end
	end
endmodule

// file: dv/tb.sv
`timescale 1ns/10ps
module tb;
	logic mclk, reset, cyc, stb, we, ack, fire, in_service, ie, nmi, periph_int;
	logic main_osc_en, sub_osc_en, port_hold, ram_retain, cpu_halt;
	logic wake_pulse, wake_ack, wake_pending, wake_branch;
	logic [3:0] adr;
	logic [31:0] wdat, rdat, dat_o;
	logic [1:0] src;
	logic [2:0] prio, sprio, pprio;
	logic [6:0] ext_int, mask;
	logic [standby_pkg::G_W-1:0] clk_en;
	int n_errors = 0;
	int num_checks = 0;
	int cnt;
	// per case: src, prio, in_service, service prio, ie, expected {ack,pend,branch}, compare mask
	logic [15:0] tbl [5] = '{16'h042F, 16'hAD57, 16'h8DEF, 16'h606F, 16'hA001};

	standby_mode_controller standby_mode_controller_inst (.mclk(mclk), .reset(reset), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o),
		.wb_ack_o(ack), .nmi(nmi), .ext_int(ext_int), .ext_int_mask(mask), .periph_int(periph_int),
		.periph_prio(pprio), .in_service(in_service), .service_prio(sprio), .interrupts_enabled_state(ie),
		.clk_en(clk_en), .main_osc_en(main_osc_en), .sub_osc_en(sub_osc_en), .port_hold(port_hold),
		.ram_retain(ram_retain), .cpu_halt(cpu_halt), .wake_pulse(wake_pulse), .wake_ack(wake_ack),
		.wake_pending(wake_pending), .wake_branch(wake_branch));
	irq_source_model irq_source_model_inst (.mclk(mclk), .reset(reset), .fire(fire), .src(src), .prio(prio),
		.wake_pulse(wake_pulse), .nmi(nmi), .ext_int(ext_int), .periph_int(periph_int), .periph_prio(pprio));

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		@(posedge mclk);
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= a;
		wdat <= d;
		for (n = 0; n < 20 && ack !== 1'h1; n++) @(posedge mclk);
		if (ack !== 1'h1) begin
			n_errors++;
			end_of_test();
		end
		rdat = dat_o;
		cyc <= 1'h0;
		stb <= 1'h0;
		we <= 1'h0;
	endtask

	// edges until the resume state shows, compared against a window
	task automatic wait_wake(input int lo, input int hi);
		for (cnt = 1; cnt <= 3000; cnt++) begin
			@(posedge mclk);
			if (wake_pulse === 1'h1) break;
		end
		check("wake latency", 32'((cnt >= lo) && (cnt <= hi)), 32'h1);
		if (cnt > 3000) end_of_test();
	endtask

	function automatic logic [20:0] exp_en(input logic [9:0] s);
		logic [20:0] e;
		e = 21'h100000; // key interrupt keeps its clock
		e[standby_pkg::G_TMR8_0] = s[standby_pkg::SEL_TMR8_0];
		e[standby_pkg::G_TMR8_1] = s[standby_pkg::SEL_TMR8_1];
		e[standby_pkg::G_TIMER_H_CHANNEL1] = s[standby_pkg::SEL_SUB_USED] & s[standby_pkg::SEL_TIMER_H_CHANNEL1_SUB];
		e[standby_pkg::G_WATCH] = s[standby_pkg::SEL_SUB_USED] | s[standby_pkg::SEL_WATCH_MAIN];
		e[standby_pkg::G_WDT2] = s[standby_pkg::SEL_SUB_USED] & s[standby_pkg::SEL_WDT2_SUB];
		e[standby_pkg::G_CSI0 +: 3] = s[standby_pkg::SEL_CSI0 +: 3];
		e[standby_pkg::G_UART0] = s[standby_pkg::SEL_UART0_EXT];
		return e;
	endfunction

	task automatic enter(input logic deep, input logic [9:0] s);
		bus(1'h1, standby_pkg::ADDR_CLKSEL, {22'h0, s});
		bus(1'h1, standby_pkg::ADDR_MODE, {31'h0, deep} << standby_pkg::DEPTH_BIT);
		bus(1'h1, standby_pkg::ADDR_CTRL, 32'h1 << standby_pkg::TRIGGER_BIT);
		repeat (5) @(posedge mclk);
	endtask

	task automatic chk_standby(input logic deep, input logic [9:0] s);
		logic [20:0] m;
		m = deep ? ~(21'h1 << standby_pkg::G_WATCH) : 21'h1FFFFF;
		check("clk_en", 32'(clk_en & m), 32'(exp_en(s) & m));
		check("main_osc_en", 32'(main_osc_en), 32'(!deep));
		check("sub_osc_en", 32'(sub_osc_en), 32'(s[standby_pkg::SEL_SUB_USED]));
		check("hold levels", 32'({port_hold, ram_retain, cpu_halt}), 32'h7);
		bus(1'h0, standby_pkg::ADDR_STATUS, 32'h0);
		check("state", rdat, deep ? 32'h2 : 32'h1);
	endtask

	initial begin
		mclk = 1'h0;
		forever #12.5 mclk = ~mclk;
	end

	initial begin
		#2500000;
		n_errors++;
		end_of_test();
	end

	initial begin
		logic [15:0] c;
		logic [9:0] s;
		reset = 1'h1;
		{cyc, stb, we, fire, in_service, ie} = 6'h00;
		{adr, wdat, src, prio, sprio, mask} = '0;
		repeat (4) @(posedge mclk);
		reset <= 1'h0;
		bus(1'h1, standby_pkg::ADDR_CLKSEL, 32'h2AA);
		bus(1'h0, standby_pkg::ADDR_CLKSEL, 32'h0);
		check("clksel readback", rdat, 32'h2AA);
		bus(1'h1, 4'h2, 32'hFFFFFFFF);
		bus(1'h0, 4'h2, 32'h0);
		check("unmapped read", rdat, 32'h0);
		for (int i = 0; i < 5; i++) begin
			c = tbl[i];
			src <= c[15:14];
			prio <= c[13:11];
			in_service <= c[10];
			sprio <= c[9:7];
			ie <= c[6];
			s = i[0] ? 10'h2AA : 10'h155;
			enter(1'h0, s);
			chk_standby(1'h0, s);
			fire <= 1'h1;
			@(posedge mclk);
			fire <= 1'h0;
			wait_wake(2, 2);
			bus(1'h0, standby_pkg::ADDR_STATUS, 32'h0);
			check("state after wake", rdat, 32'h0);
			check("clk_en after wake", 32'(clk_en), 32'h1FFFFF);
			check("wake flags", 32'({wake_ack, wake_pending, wake_branch} & c[2:0]), 32'(c[5:3] & c[2:0]));
		end
		// masked pin must not end deep standby, unmasking it must
		src <= 2'h1;
		prio <= 3'h6;
		in_service <= 1'h0;
		ie <= 1'h1;
		mask <= 7'h7F;
		enter(1'h1, 10'h2AA);
		fire <= 1'h1;
		@(posedge mclk);
		fire <= 1'h0;
		repeat (20) @(posedge mclk);
		chk_standby(1'h1, 10'h2AA);
		mask <= 7'h00;
		wait_wake(standby_pkg::OSC_STAB_CYC + 1, standby_pkg::OSC_STAB_CYC + 3);
		bus(1'h0, standby_pkg::ADDR_STATUS, 32'h0);
		check("state after deep", rdat, 32'h0);
		check("main osc back", 32'(main_osc_en), 32'h1);
		enter(1'h0, 10'h155);
		reset <= 1'h1;
		repeat (2) @(posedge mclk);
		reset <= 1'h0;
		check("clk_en after reset", 32'(clk_en), 32'h1FFFFF);
		check("levels after reset", 32'({main_osc_en, port_hold, cpu_halt}), 32'h4);
		bus(1'h0, standby_pkg::ADDR_CLKSEL, 32'h0);
		check("clksel after reset", rdat, 32'h0);
		bus(1'h0, standby_pkg::ADDR_STATUS, 32'h0);
		check("state after reset", rdat, 32'h0);
		end_of_test();
	end
endmodule
